/* rtl/bi_board_info.v */
/*
 Board information flags, jumper readback and per-target options
 with a small command retry and reconnect engine, behind Avalon-MM.
 Assumes jumper, fuse and sequencer inputs synchronous to clk_sys.
*/
// Chosen here: the Avalon-MM register port and the register addresses.
// Notes on behaviour
// - Reset bit reads one when bus reset
// - Own ID in option bits 0,7,6,5
// - Termination bit 1 flags low power
// - Termination bit 2 flags blown fuse
// - Jumper byte, bit 7 first pair
// - Jumper roles; absent ID jumper gives 0
// - Wait disconnect timeout, then start recovery
// - Retries never exceed per-target limit
// - Flag bits 15,13,7,5,4 read zero
// - Bit 0 allows multi-LUN command queuing
// - Bit 1 starts period negotiation
// - Bit 2 suppresses attention toward target
// - Bit 3 starts bus size negotiation
// - Bit 6 only records tagged request
// - Bit 9 gives status per retry
// - Bit 8 with 9 interrupts host
// - Bit 10 retries parity failures
// - Bit 11 retries device errors
// - Bit 12 retries bus faults
// - Bit 14 selects 16 sense bytes
// - Period value counts 4 ns units
// - Fixed base model code reported
`timescale 1ns/1ps
`default_nettype none
`include "bi_board_info_map.vh"

module bi_board_info (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Avalon-MM slave
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Board inputs
  input wire [7:0] jumper_in,
  input wire term_power_low,
  input wire term_fuse_blown,
  // Sequencer events
  input wire seq_start,
  input wire [3:0] seq_target,
  input wire seq_disconnect,
  input wire seq_reconnect,
  input wire seq_fail,
  input wire [1:0] seq_fail_kind,
  input wire seq_done,
  // Board configuration
  output reg [3:0] adapter_id,
  output reg parity_check_en,
  output reg bus_reset_at_powerup,
  // Current target configuration
  output reg untagged_multi_lun_queue,
  output reg initiate_period_negotiation,
  output reg atn_allowed,
  output reg initiate_bus_size_negotiation,
  output reg tag_queue_enabled,
  output reg sense_selected,
  output reg [4:0] sense_bytes,
  output reg [5:0] min_edge_gap,
  // Engine events
  output reg retry_pulse,
  output reg status_block_pulse,
  output reg host_irq_pulse,
  output reg error_pulse,
  output reg recover_pulse
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LOAD = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;
  localparam [1:0] ST_WAIT = 2'h3;
  localparam integer TICK_LAST_I = `BI_TICK_CYC - 1;
  localparam [11:0] TICK_LAST = TICK_LAST_I[11:0];

  // Snapshot of board inputs
  reg [7:0] jumper_reg;
  reg low_term_power_reg;
  reg term_fuse_blown_reg;
  reg snap_pend_reg;

  // Control registers
  reg disc_en_reg;
  reg [3:0] tsel_reg;

  // Bus handshake
  wire [3:0] reg_idx;
  wire bus_req;
  wire wr_take;
  wire [15:0] wr_flags;
  reg [31:0] rd_mux;

  // Store
  wire [`BI_ENT_W-1:0] mem_a;
  wire [`BI_ENT_W-1:0] mem_b;
  reg mem_wr;
  reg [`BI_ENT_W-1:0] mem_wdata;

  // Engine
  reg [1:0] state_reg;
  reg [3:0] tgt_reg;
  reg [7:0] retry_cnt_reg;
  reg [15:0] tmo_cnt_reg;
  reg [11:0] tick_reg;

  wire [15:0] a_flags;
  wire [7:0] a_period;
  wire [10:0] a_ns;
  wire [10:0] a_gap;
  wire [15:0] b_flags;
  wire [7:0] b_retry;
  wire [7:0] b_period;
  wire [15:0] b_tmo;
  wire [10:0] b_ns;
  wire [10:0] b_gap;
  wire [7:0] opt_byte;
  wire [7:0] term_byte;
  reg kind_ok;

  assign reg_idx = avs_address[5:2];
  assign bus_req = avs_read | avs_write;
  assign wr_take = avs_write & ~avs_waitrequest;
  assign wr_flags = avs_writedata[15:0] & `BI_FLAGS_MASK;

  assign a_flags = mem_a[15:0];
  assign a_period = mem_a[31:24];
  assign b_flags = mem_b[15:0];
  assign b_retry = mem_b[23:16];
  assign b_period = mem_b[31:24];
  assign b_tmo = mem_b[47:32];

  // Period in ns, rounded up to whole clocks
  assign a_ns = {1'b0, a_period, 2'b00};
  assign a_gap = (a_ns + 11'd24) / 11'd25;
  assign b_ns = {1'b0, b_period, 2'b00};
  assign b_gap = (b_ns + 11'd24) / 11'd25;

  // Reset jumper out means reset selected
  assign opt_byte = {jumper_reg[2:0], ~jumper_reg[`BI_JMP_RESET], 3'b000,
    jumper_reg[`BI_JMP_ID3]};
  assign term_byte = {5'b00000, term_fuse_blown_reg, low_term_power_reg,
    1'b0};

  // Read data mux
  always @* begin
    rd_mux = 32'h0000_0000;
    case (reg_idx)
      `BI_OFS_MODEL: rd_mux = {16'h0000, `BI_MODEL_CODE};
      `BI_OFS_OPTION: rd_mux = {24'h000000, opt_byte};
      `BI_OFS_TERM: rd_mux = {24'h000000, term_byte};
      `BI_OFS_JUMPER: rd_mux = {24'h000000, jumper_reg};
      `BI_OFS_CTRL: rd_mux = {30'h0, disc_en_reg, 1'b0};
      `BI_OFS_TSEL: rd_mux = {28'h0, tsel_reg};
      `BI_OFS_TFLAGS: rd_mux = {16'h0000, a_flags & `BI_FLAGS_MASK};
      `BI_OFS_TPARAM: rd_mux = {16'h0000, mem_a[31:16]};
      `BI_OFS_TTIMEOUT: rd_mux = {16'h0000, mem_a[47:32]};
      `BI_OFS_TSTAT: rd_mux = {6'h00, a_ns[9:0], 10'h000, a_gap[5:0]};
      `BI_OFS_ESTAT: rd_mux = {6'h00, tmo_cnt_reg[5:0], retry_cnt_reg,
        tgt_reg, 6'h00, state_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Store write: merge the written field into the selected entry
  always @* begin
    mem_wr = 1'b0;
    mem_wdata = mem_a;
    if (wr_take) begin
      case (reg_idx)
        `BI_OFS_TFLAGS: begin
          mem_wr = 1'b1;
          if (avs_byteenable[0]) begin
            mem_wdata[7:0] = wr_flags[7:0];
          end
          if (avs_byteenable[1]) begin
            mem_wdata[15:8] = wr_flags[15:8];
          end
        end
        `BI_OFS_TPARAM: begin
          mem_wr = 1'b1;
          if (avs_byteenable[0]) begin
            mem_wdata[23:16] = avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            mem_wdata[31:24] = avs_writedata[15:8];
          end
        end
        `BI_OFS_TTIMEOUT: begin
          mem_wr = 1'b1;
          if (avs_byteenable[0]) begin
            mem_wdata[39:32] = avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            mem_wdata[47:40] = avs_writedata[15:8];
          end
        end
        default: mem_wr = 1'b0;
      endcase
    end
  end

  bi_target_mem u_mem (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wr_en(mem_wr),
    .wr_addr(tsel_reg),
    .wr_data(mem_wdata),
    .a_addr(tsel_reg),
    .a_data(mem_a),
    .b_addr(tgt_reg),
    .b_data(mem_b)
  );

  // Bus slave: one wait cycle, answer, then take the write
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      disc_en_reg <= 1'b0;
      tsel_reg <= 4'h0;
    end else begin
      if (!avs_waitrequest) begin
        avs_waitrequest <= 1'b1;
      end else if (bus_req) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
      end
      if (wr_take && avs_byteenable[0]) begin
        if (reg_idx == `BI_OFS_CTRL) begin
          disc_en_reg <= avs_writedata[`BI_CTRL_DISC_EN];
        end
        if (reg_idx == `BI_OFS_TSEL) begin
          tsel_reg <= avs_writedata[3:0];
        end
      end
    end
  end

  // Fresh sample after reset and on each capture request
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      snap_pend_reg <= 1'b1;
      jumper_reg <= 8'h00;
      low_term_power_reg <= 1'b0;
      term_fuse_blown_reg <= 1'b0;
      adapter_id <= 4'h0;
      parity_check_en <= 1'b0;
      bus_reset_at_powerup <= 1'b0;
    end else begin
      snap_pend_reg <= wr_take && reg_idx == `BI_OFS_CTRL &&
        avs_byteenable[0] && avs_writedata[`BI_CTRL_CAPTURE];
      if (snap_pend_reg) begin
        jumper_reg <= jumper_in;
        low_term_power_reg <= term_power_low;
        term_fuse_blown_reg <= term_fuse_blown;
        adapter_id <= jumper_in[3:0];
        parity_check_en <= ~jumper_in[`BI_JMP_PARITY];
        bus_reset_at_powerup <= ~jumper_in[`BI_JMP_RESET];
      end
    end
  end

  // Failure kind matched against its retry option
  always @* begin
    case (seq_fail_kind)
      `BI_FAIL_PARITY: kind_ok = b_flags[`BI_FLG_RETRY_PAR];
      `BI_FAIL_DEVICE: kind_ok = b_flags[`BI_FLG_RETRY_DEV];
      `BI_FAIL_BUS: kind_ok = b_flags[`BI_FLG_RETRY_BUS];
      default: kind_ok = 1'b0;
    endcase
  end

  // Command engine for the active target
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      tgt_reg <= 4'h0;
      retry_cnt_reg <= 8'h00;
      tmo_cnt_reg <= 16'h0000;
      tick_reg <= 12'h000;
      retry_pulse <= 1'b0;
      status_block_pulse <= 1'b0;
      host_irq_pulse <= 1'b0;
      error_pulse <= 1'b0;
      recover_pulse <= 1'b0;
    end else begin
      retry_pulse <= 1'b0;
      status_block_pulse <= 1'b0;
      host_irq_pulse <= 1'b0;
      error_pulse <= 1'b0;
      recover_pulse <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (seq_start) begin
            tgt_reg <= seq_target;
            retry_cnt_reg <= 8'h00;
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // Entry read lags the address by one clock
          state_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (seq_done) begin
            state_reg <= ST_IDLE;
          end else if (seq_fail) begin
            if (kind_ok && retry_cnt_reg < b_retry) begin
              retry_cnt_reg <= retry_cnt_reg + 8'h01;
              retry_pulse <= 1'b1;
              status_block_pulse <= b_flags[`BI_FLG_ISB];
              host_irq_pulse <= b_flags[`BI_FLG_ISB] &
                b_flags[`BI_FLG_INT];
            end else begin
              error_pulse <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end else if (seq_disconnect && disc_en_reg) begin
            tmo_cnt_reg <= 16'h0000;
            tick_reg <= 12'h000;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (seq_reconnect) begin
            state_reg <= ST_RUN;
          end else if (tmo_cnt_reg >= b_tmo) begin
            recover_pulse <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (tick_reg == TICK_LAST) begin
            tick_reg <= 12'h000;
            tmo_cnt_reg <= tmo_cnt_reg + 16'h0001;
          end else begin
            tick_reg <= tick_reg + 12'h001;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Options of the active target, held in flops
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      untagged_multi_lun_queue <= 1'b0;
      initiate_period_negotiation <= 1'b0;
      atn_allowed <= 1'b1;
      initiate_bus_size_negotiation <= 1'b0;
      tag_queue_enabled <= 1'b0;
      sense_selected <= 1'b0;
      sense_bytes <= `BI_SENSE_DEF;
      min_edge_gap <= 6'h00;
    end else begin
      untagged_multi_lun_queue <= b_flags[`BI_FLG_MULTI_LUN];
      initiate_period_negotiation <=
        b_flags[`BI_FLG_NEG_PERIOD];
      atn_allowed <= ~b_flags[`BI_FLG_NO_ATN];
      initiate_bus_size_negotiation <=
        b_flags[`BI_FLG_NEG_SIZE];
      // Request only; real tag mode is not tracked here
      tag_queue_enabled <= b_flags[`BI_FLG_TAG_Q];
      sense_selected <= b_flags[`BI_FLG_SEL_SENSE];
      sense_bytes <= b_flags[`BI_FLG_SEL_SENSE] ? `BI_SENSE_SEL :
        `BI_SENSE_DEF;
      min_edge_gap <= b_gap[5:0];
    end
  end

endmodule
`default_nettype wire

/* pkg/bi_board_info_map.vh */
/*
 Register offsets, field positions, reset values and timing counts
 for the board information block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef BI_BOARD_INFO_MAP_VH
`define BI_BOARD_INFO_MAP_VH

// Avalon register indexes, compared with address bits 5:2
`define BI_OFS_MODEL 4'h0
`define BI_OFS_OPTION 4'h1
`define BI_OFS_TERM 4'h2
`define BI_OFS_JUMPER 4'h3
`define BI_OFS_CTRL 4'h4
`define BI_OFS_TSEL 4'h5
`define BI_OFS_TFLAGS 4'h6
`define BI_OFS_TPARAM 4'h7
`define BI_OFS_TTIMEOUT 4'h8
`define BI_OFS_TSTAT 4'h9
`define BI_OFS_ESTAT 4'ha

// Identity value is arbitrary
`define BI_MODEL_CODE 16'h0b1c

// Control register bits
`define BI_CTRL_CAPTURE 0
`define BI_CTRL_DISC_EN 1

// Jumper byte bit positions
`define BI_JMP_PARITY 5
`define BI_JMP_RESET 4
`define BI_JMP_ID3 3

// Option byte positions
`define BI_OPT_ID3 0
`define BI_OPT_RST 4

// Termination byte positions
`define BI_TERM_LOW_PWR 1
`define BI_TERM_FUSE 2

// Device flag bit positions
`define BI_FLG_MULTI_LUN 0
`define BI_FLG_NEG_PERIOD 1
`define BI_FLG_NO_ATN 2
`define BI_FLG_NEG_SIZE 3
`define BI_FLG_TAG_Q 6
`define BI_FLG_INT 8
`define BI_FLG_ISB 9
`define BI_FLG_RETRY_PAR 10
`define BI_FLG_RETRY_DEV 11
`define BI_FLG_RETRY_BUS 12
`define BI_FLG_SEL_SENSE 14
`define BI_FLAGS_MASK 16'h5f4f

// Target entry layout
`define BI_ENT_W 48
`define BI_FLAGS_RESET 16'h0000
`define BI_ENT_RESET 48'h0000_0000_0000

// Failure kinds from the sequencer
`define BI_FAIL_PARITY 2'h0
`define BI_FAIL_DEVICE 2'h1
`define BI_FAIL_BUS 2'h2

// Timing and sense byte counts
`define BI_CLK_NS 25
`define BI_PERIOD_UNIT_NS 4
`define BI_TICK_NS 100000
`define BI_TICK_CYC (`BI_TICK_NS / `BI_CLK_NS)
`define BI_SENSE_SEL 5'h10
`define BI_SENSE_DEF 5'h08

`endif

/* rtl/bi_target_mem.v */
/*
 Sixteen-entry per-target option store, one write port and two read
 ports whose data come out of registers.
 Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bi_board_info_map.vh"

module bi_target_mem (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Write port
  input wire wr_en,
  input wire [3:0] wr_addr,
  input wire [`BI_ENT_W-1:0] wr_data,
  // Read ports
  input wire [3:0] a_addr,
  output reg [`BI_ENT_W-1:0] a_data,
  input wire [3:0] b_addr,
  output reg [`BI_ENT_W-1:0] b_data
);

  wire [`BI_ENT_W-1:0] ent [0:15];

  // Reset store so options are defined after reset
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_ent
      reg [`BI_ENT_W-1:0] ent_reg;
      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          ent_reg <= `BI_ENT_RESET;
        end else if (wr_en && wr_addr == i) begin
          ent_reg <= wr_data;
        end
      end
      assign ent[i] = ent_reg;
    end
  endgenerate

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      a_data <= `BI_ENT_RESET;
      b_data <= `BI_ENT_RESET;
    end else begin
      a_data <= ent[a_addr];
      b_data <= ent[b_addr];
    end
  end

endmodule
`default_nettype wire

/* testbench/bi_seq_model.sv */
/*
 Sequencer model that issues command events to the block.
 Assumes calls from the bench through the send task only.
*/
`timescale 1ns/1ps
`default_nettype none
module bi_seq_model (
  // Clock
  input wire clk_sys,
  // Sequencer events
  output var logic seq_start,
  output var logic [3:0] seq_target,
  output var logic seq_disconnect,
  output var logic seq_reconnect,
  output var logic seq_fail,
  output var logic [1:0] seq_fail_kind,
  output var logic seq_done
);
  initial begin
    {seq_start, seq_disconnect, seq_reconnect, seq_fail, seq_done} = 5'h0;
    seq_target = 4'h0;
    seq_fail_kind = 2'h0;
  end
  // Kind: 0 start, 1 fail, 2 disconnect, 3 done, 4 reconnect
  task automatic send(input int which, input [3:0] t, input [1:0] k);
    @(posedge clk_sys);
    seq_target <= t;
    seq_fail_kind <= k;
    seq_start <= (which == 0);
    seq_fail <= (which == 1);
    seq_disconnect <= (which == 2);
    seq_done <= (which == 3);
    seq_reconnect <= (which == 4);
    @(posedge clk_sys);
    {seq_start, seq_disconnect, seq_reconnect, seq_fail, seq_done} <= 5'h0;
    // Stale qualifiers flip so nobody can lean on them
    seq_target <= ~t;
    seq_fail_kind <= ~k;
  endtask
endmodule
`default_nettype wire

/* testbench/bi_board_info_sva.sv */
/*
 Checker for the board information block.
 Assumes binding onto bi_board_info and the shared map header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bi_board_info_map.vh"
module bi_board_info_sva (
  // Clock, reset and bus
  input wire clk_sys,
  input wire rst_b,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Board and event outputs
  input wire [3:0] adapter_id,
  input wire parity_check_en,
  input wire bus_reset_at_powerup,
  input wire sense_selected,
  input wire [4:0] sense_bytes,
  input wire retry_pulse,
  input wire status_block_pulse,
  input wire host_irq_pulse,
  input wire error_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire [3:0] ofs = avs_address[5:2];
  wire rd_ok = avs_read && !avs_waitrequest;
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  answer_once_a: assert property (s_taken |=> s_answer)
    else $error("bus answer not one cycle");
  option_map_a: assert property (rd_ok && ofs == `BI_OFS_OPTION |->
    avs_readdata[7:0] == {adapter_id[2:0], bus_reset_at_powerup, 3'h0,
    adapter_id[3]}) else $error("option byte wrong");
  jumper_map_a: assert property (rd_ok && ofs == `BI_OFS_JUMPER |->
    avs_readdata[3:0] == adapter_id && avs_readdata[5] == !parity_check_en)
    else $error("jumper roles wrong");
  model_code_a: assert property (rd_ok && ofs == `BI_OFS_MODEL |->
    avs_readdata[15:0] == `BI_MODEL_CODE) else $error("model code wrong");
  term_zero_a: assert property (rd_ok && ofs == `BI_OFS_TERM |->
    avs_readdata[7:3] == 5'h0 && !avs_readdata[0])
    else $error("term spare bits set");
  flag_zero_a: assert property (rd_ok && ofs == `BI_OFS_TFLAGS |->
    (avs_readdata[15:0] & ~`BI_FLAGS_MASK) == 16'h0)
    else $error("flag spare bits set");
  sense_count_a: assert property (sense_bytes ==
    (sense_selected ? `BI_SENSE_SEL : `BI_SENSE_DEF))
    else $error("sense count wrong");
  irq_needs_status_a: assert property (host_irq_pulse |->
    status_block_pulse) else $error("interrupt without status");
  status_on_retry_a: assert property (status_block_pulse |->
    retry_pulse) else $error("status without retry");
  retry_excl_a: assert property (retry_pulse |-> !error_pulse)
    else $error("retry and error together");
endmodule
bind bi_board_info bi_board_info_sva u_sva (.clk_sys(clk_sys),
  .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .adapter_id(adapter_id),
  .parity_check_en(parity_check_en),
  .bus_reset_at_powerup(bus_reset_at_powerup),
  .sense_selected(sense_selected), .sense_bytes(sense_bytes),
  .retry_pulse(retry_pulse), .status_block_pulse(status_block_pulse),
  .host_irq_pulse(host_irq_pulse), .error_pulse(error_pulse));
`default_nettype wire

/* testbench/bi_board_info_test.sv */
/*
 Self-checking bench for the board information block.
 Assumes the sequencer model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bi_board_info_map.vh"
module bi_board_info_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] avs_address = 6'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [7:0] jumper_in = 8'h2b;
  logic term_power_low = 1'b1;
  logic term_fuse_blown = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, seq_start, seq_disconnect, seq_reconnect, seq_fail;
  wire seq_done, parity_check_en, bus_reset_at_powerup, atn_allowed;
  wire untagged_multi_lun_queue, initiate_period_negotiation;
  wire initiate_bus_size_negotiation, tag_queue_enabled, sense_selected;
  wire retry_pulse, status_block_pulse, host_irq_pulse, error_pulse;
  wire recover_pulse;
  wire [3:0] seq_target, adapter_id;
  wire [1:0] seq_fail_kind;
  wire [4:0] sense_bytes;
  wire [5:0] min_edge_gap;
  int errors = 0;
  int num_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  bi_seq_model u_seq (.clk_sys(clk_sys), .seq_start(seq_start),
    .seq_target(seq_target), .seq_disconnect(seq_disconnect),
    .seq_reconnect(seq_reconnect), .seq_fail(seq_fail),
    .seq_fail_kind(seq_fail_kind), .seq_done(seq_done));
  bi_board_info u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .jumper_in(jumper_in), .term_power_low(term_power_low),
    .term_fuse_blown(term_fuse_blown), .seq_start(seq_start),
    .seq_target(seq_target), .seq_disconnect(seq_disconnect),
    .seq_reconnect(seq_reconnect), .seq_fail(seq_fail),
    .seq_fail_kind(seq_fail_kind), .seq_done(seq_done),
    .adapter_id(adapter_id), .parity_check_en(parity_check_en),
    .bus_reset_at_powerup(bus_reset_at_powerup),
    .untagged_multi_lun_queue(untagged_multi_lun_queue),
    .initiate_period_negotiation(initiate_period_negotiation),
    .atn_allowed(atn_allowed),
    .initiate_bus_size_negotiation(initiate_bus_size_negotiation),
    .tag_queue_enabled(tag_queue_enabled), .sense_selected(sense_selected),
    .sense_bytes(sense_bytes), .min_edge_gap(min_edge_gap),
    .retry_pulse(retry_pulse), .status_block_pulse(status_block_pulse),
    .host_irq_pulse(host_irq_pulse), .error_pulse(error_pulse),
    .recover_pulse(recover_pulse));
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timed_out(input int n);
    errors++;
    $display("FAIL at %0t: waited %h cycles, expected %h", $time, n, 0);
    give_verdict();
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input bit wr, input [3:0] ofs, input [15:0] d,
                     output [31:0] q);
    int n;
    @(posedge clk_sys);
    avs_address <= {ofs, 2'b00};
    avs_writedata <= {16'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) timed_out(n);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input [3:0] ofs, input [15:0] d);
    logic [31:0] q;
    bus(1'b1, ofs, d, q);
  endtask
  task automatic rdc(input [3:0] ofs, input [31:0] exp);
    logic [31:0] q;
    bus(1'b0, ofs, 16'h0, q);
    check(q, exp);
  endtask
  // Waits for the first engine pulse and compares the whole set
  task automatic expect_evt(input [4:0] exp, input int lim, output int n);
    logic [4:0] v;
    n = 0;
    v = 5'h0;
    while (v === 5'h0 && n < lim) begin
      @(posedge clk_sys);
      n++;
      v = {retry_pulse, status_block_pulse, host_irq_pulse, error_pulse,
           recover_pulse};
    end
    if (v === 5'h0) timed_out(n);
    check(32'(v), 32'(exp));
  endtask
  task automatic t_board();
    rdc(`BI_OFS_MODEL, 32'(`BI_MODEL_CODE));
    rdc(`BI_OFS_OPTION, 32'h71);
    rdc(`BI_OFS_TERM, 32'h02);
    rdc(`BI_OFS_JUMPER, 32'h2b);
    check(32'({adapter_id, parity_check_en}), 32'h16);
    wr(`BI_OFS_MODEL, 16'hffff);
    rdc(`BI_OFS_MODEL, 32'(`BI_MODEL_CODE));
    rdc(4'hf, 32'h0);
    jumper_in <= 8'hd4;
    term_power_low <= 1'b0;
    term_fuse_blown <= 1'b1;
    rdc(`BI_OFS_JUMPER, 32'h2b);
    wr(`BI_OFS_CTRL, 16'h1);
    rdc(`BI_OFS_OPTION, 32'h80);
    rdc(`BI_OFS_TERM, 32'h04);
    rdc(`BI_OFS_JUMPER, 32'hd4);
    check(32'({adapter_id, parity_check_en}), 32'h09);
    $display("t_board done");
  endtask
  task automatic t_flags();
    wr(`BI_OFS_TSEL, 16'h3);
    wr(`BI_OFS_TFLAGS, 16'hffff);
    rdc(`BI_OFS_TFLAGS, 32'h5f4f);
    wr(`BI_OFS_TPARAM, 16'h0d02);
    rdc(`BI_OFS_TSTAT, 32'h0034_0003);
    u_seq.send(0, 4'h3, 2'h0);
    repeat (3) @(posedge clk_sys);
    check(32'({untagged_multi_lun_queue, initiate_period_negotiation,
      atn_allowed, initiate_bus_size_negotiation, tag_queue_enabled,
      sense_selected, sense_bytes, min_edge_gap}), 32'h1bc03);
    u_seq.send(3, 4'h3, 2'h0);
    wr(`BI_OFS_TFLAGS, 16'h0000);
    u_seq.send(0, 4'h3, 2'h0);
    repeat (3) @(posedge clk_sys);
    check(32'({untagged_multi_lun_queue, initiate_period_negotiation,
      atn_allowed, initiate_bus_size_negotiation, tag_queue_enabled,
      sense_selected, sense_bytes, min_edge_gap}), 32'h04203);
    u_seq.send(3, 4'h3, 2'h0);
    $display("t_flags done");
  endtask
  task automatic t_retry();
    int n;
    wr(`BI_OFS_TPARAM, 16'h0d01);
    wr(`BI_OFS_TFLAGS, 16'h1300);
    u_seq.send(0, 4'h3, 2'h0);
    u_seq.send(1, 4'h3, `BI_FAIL_BUS);
    expect_evt(5'b11100, 20, n);
    u_seq.send(1, 4'h3, `BI_FAIL_BUS);
    expect_evt(5'b00010, 20, n);
    // Each failure kind retried only under its own bit
    for (int k = 0; k < 3; k++) begin
      wr(`BI_OFS_TFLAGS, 16'h0400 << k);
      u_seq.send(0, 4'h3, 2'h0);
      u_seq.send(1, 4'h3, k[1:0]);
      expect_evt(5'b10000, 20, n);
      u_seq.send(1, 4'h3, k[1:0]);
      expect_evt(5'b00010, 20, n);
      wr(`BI_OFS_TFLAGS, 16'h0000);
      u_seq.send(0, 4'h3, 2'h0);
      u_seq.send(1, 4'h3, k[1:0]);
      expect_evt(5'b00010, 20, n);
    end
    // Kind 3 is never retried, whatever the options
    wr(`BI_OFS_TFLAGS, 16'h1c00);
    u_seq.send(0, 4'h3, 2'h0);
    u_seq.send(1, 4'h3, 2'h3);
    expect_evt(5'b00010, 20, n);
    $display("t_retry done");
  endtask
  task automatic t_disc();
    int n;
    wr(`BI_OFS_CTRL, 16'h2);
    wr(`BI_OFS_TTIMEOUT, 16'h0);
    u_seq.send(0, 4'h3, 2'h0);
    u_seq.send(2, 4'h3, 2'h0);
    expect_evt(5'b00001, 20, n);
    wr(`BI_OFS_TTIMEOUT, 16'h1);
    u_seq.send(0, 4'h3, 2'h0);
    u_seq.send(2, 4'h3, 2'h0);
    expect_evt(5'b00001, 4100, n);
    check(32'(n >= `BI_TICK_CYC), 32'h1);
    // Reconnect must return to the run state before the timeout
    u_seq.send(0, 4'h3, 2'h0);
    u_seq.send(2, 4'h3, 2'h0);
    u_seq.send(4, 4'h3, 2'h0);
    u_seq.send(1, 4'h3, 2'h3);
    expect_evt(5'b00010, 20, n);
    $display("t_disc done");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_board();
    t_flags();
    t_retry();
    t_disc();
    give_verdict();
  end
endmodule
`default_nettype wire
